// ---- sfpc_top.sv ----
// Switching frequency and phase control for four internal switchers.
// Assumes a command decoder on the same clock delivers write and read
// strobes; no synchroniser is needed on them.
//
// Function
// RULE1 - Channels sit at A 0, C 90, B 180, D 270 degrees.
// RULE2 - All channel frequencies come only from the master channel command.
// RULE3 - Master acknowledges commands from 200 kHz to 2 MHz, 1 kHz steps.
// RULE4 - Command becomes whole count of 48 MHz cycles, nearest achievable frequency.
// RULE5 - Fraction of 0.5 or more rounds the count up, else down.
// RULE6 - Writes to A, B, D are acknowledged but do not change B or D.
// RULE7 - Reads of A, B, D return the value last written there.
// RULE8 - Written A value below master frequency runs A at half master.
// RULE9 - B and D always run at the master frequency.
// RULE10 - Master below 400 kHz forces A to master frequency.
// RULE11 - Channel A never runs below 200 kHz.
// RULE12 - Written A value at or above master runs A at master frequency.
// RULE13 - C, B, D periods start a quarter, half, three quarters after A.
`timescale 1ns/1ps
module sfpc_top
    import sfpc_pkg::*;
(
    input  wire logic             CLK,
    input  wire logic             RESETN,
    input  wire logic             FREQ_WR,
    input  wire logic             FREQ_RD,
    input  wire logic [1:0]       FREQ_CH,
    input  wire logic [KHZ_W-1:0] FREQ_WDATA,
    output logic                  FREQ_ACK,
    output logic                  FREQ_NACK,
    output logic                  FREQ_RVALID,
    output logic [KHZ_W-1:0]      FREQ_RDATA,
    output logic [3:0]            PERIOD_START,
    output logic [CNT_W-1:0]      MASTER_CYCLES,
    output logic                  HALF_RATE_A
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (FMAX_KHZ >= (1 << KHZ_W)) begin : g_chk_khz
        $error("kHz width too small for the command range");
    end
    if ((2 * BASE_KHZ + FMAX_KHZ) >= (1 << NUM_W)) begin : g_chk_num
        $error("numerator width too small");
    end

    typedef struct packed {
        logic [8:0]                  acc;
        logic [3:0][KHZ_W-1:0]       wr_val;
        logic [CNT_W-1:0]            n_cur;
        logic [CNT_W-1:0]            n_pend;
        logic                        pend;
        logic [CNT_W-1:0]            cnt;
        logic                        a_odd;
        logic                        half;
        logic [3:0]                  starts;
        logic                        ack;
        logic                        nack;
        logic                        rvalid;
        logic [KHZ_W-1:0]            rdata;
        logic                        div_go;
        logic [KHZ_W-1:0]            div_khz;
    } sfpc_s;

    sfpc_s s_q;
    sfpc_s s_d;

    // Longest master period, in base cycles, whose half still meets the floor
    localparam logic [CNT_W-1:0] HALF_CNT_MAX =
        CNT_W'((2 * BASE_KHZ + HALF_MIN_KHZ) / (2 * HALF_MIN_KHZ));

    sfpc_div_if div_bus ();

    sfpc_divider u_div (
        .CLK    (CLK),
        .RESETN (RESETN),
        .dv     (div_bus.ctrl)
    );

    // ************************************************************
    // Rounding divide request
    // ************************************************************
    // RULE5 round half up
    // round(48000/f) = floor((2*48000 + f) / (2*f)), exact in integers
    assign div_bus.start = s_q.div_go;
    assign div_bus.num   = NUM_W'(2 * BASE_KHZ) + NUM_W'(s_q.div_khz);
    assign div_bus.den   = {s_q.div_khz, 1'b0};

    // Range test shared by the write path
    function automatic logic in_range(input logic [KHZ_W-1:0] khz);
        return (khz >= KHZ_W'(FMIN_KHZ)) && (khz <= KHZ_W'(FMAX_KHZ));
    endfunction

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        logic             tick;
        logic [8:0]       sum;
        logic [CNT_W-1:0] q1;
        logic [CNT_W-1:0] q2;
        logic [CNT_W-1:0] q3;
        logic             wrap;
        tick = 1'b0;
        sum  = s_q.acc + TICK_INC;
        q1   = s_q.n_cur >> 2;
        q2   = s_q.n_cur >> 1;
        q3   = q1 + q2;
        wrap = 1'b0;
        s_d  = s_q;
        s_d.ack    = 1'b0;
        s_d.nack   = 1'b0;
        s_d.rvalid = 1'b0;
        s_d.div_go = 1'b0;
        s_d.starts = 4'h0;

        // 48 MHz enable from a fractional accumulator; jitter is one clock
        if (sum >= TICK_MOD) begin
            s_d.acc = sum - TICK_MOD;
            tick    = 1'b1;
        end else begin
            s_d.acc = sum;
        end

        // Write path
        if (FREQ_WR) begin
            if (FREQ_CH == CH_C) begin
                // RULE3 master range check
                if (in_range(FREQ_WDATA)) begin
                    s_d.ack           = 1'b1;
                    s_d.wr_val[CH_C]  = FREQ_WDATA;
                    s_d.div_khz       = FREQ_WDATA;
                    s_d.div_go        = 1'b1;
                end else begin
                    s_d.nack = 1'b1;
                end
            end else begin
                // RULE6 acknowledged, stored only
                s_d.ack               = 1'b1;
                s_d.wr_val[FREQ_CH]   = FREQ_WDATA;
            end
        end

        // RULE7 read back stored value
        if (FREQ_RD) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = s_q.wr_val[FREQ_CH];
        end

        // RULE4 new count waits for period end
        if (div_bus.done) begin
            s_d.n_pend = div_bus.quot;
            s_d.pend   = 1'b1;
        end

        // RULE2 single master counter
        // RULE9 B and D share master period
        if (tick) begin
            wrap = (s_q.cnt == s_q.n_cur - CNT_W'(1));
            if (wrap) begin
                s_d.cnt   = '0;
                s_d.a_odd = ~s_q.a_odd;
                if (s_q.pend) begin
                    s_d.n_cur = s_q.n_pend;
                    // A result landing on this wrap stays pending: the set wins
                    s_d.pend  = div_bus.done;
                end
            end else begin
                s_d.cnt = s_q.cnt + CNT_W'(1);
            end
            // RULE1 quarter phase slots
            // RULE13 offsets from A start
            s_d.starts[CH_A] = (s_q.cnt == '0) && !(s_q.half && s_q.a_odd);
            s_d.starts[CH_C] = (s_q.cnt == q1);
            s_d.starts[CH_B] = (s_q.cnt == q2);
            s_d.starts[CH_D] = (s_q.cnt == q3);
        end

        // RULE8 half when A below master
        // RULE10 never half below 400 kHz
        // RULE11 half only on a short enough period
        // RULE12 A at or above master runs full rate
        // The count in use is checked too: a speed-up command must not halve
        // the old, slower period before it is replaced at the wrap
        s_d.half = (s_q.wr_val[CH_A] < s_q.wr_val[CH_C])
                   && (s_q.wr_val[CH_C] >= KHZ_W'(HALF_MIN_KHZ))
                   && (s_d.n_cur <= HALF_CNT_MAX);
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            s_q        <= '0;
            s_q.wr_val <= {4{FREQ_RST_KHZ}};
            s_q.n_cur  <= CNT_RST;
            s_q.n_pend <= CNT_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign FREQ_ACK      = s_q.ack;
    assign FREQ_NACK     = s_q.nack;
    assign FREQ_RVALID   = s_q.rvalid;
    assign FREQ_RDATA    = s_q.rdata;
    assign PERIOD_START  = s_q.starts;
    assign MASTER_CYCLES = s_q.n_cur;
    assign HALF_RATE_A   = s_q.half;

endmodule

// ---- sfpc_pkg.sv ----
// Shared constants for the switcher frequency and phase control block.
// Assumes a single 250 MHz system clock and a 48 MHz internal base rate.
package sfpc_pkg;

    // ************************************************************
    // Rates and frequency limits
    // ************************************************************
    localparam int unsigned CLK_KHZ      = 250000;  // System clock rate
    localparam int unsigned BASE_KHZ     = 48000;   // Internal switcher base clock
    localparam int unsigned FMIN_KHZ     = 200;     // Lowest accepted command
    localparam int unsigned FMAX_KHZ     = 2000;    // Highest accepted command
    localparam int unsigned HALF_MIN_KHZ = 400;     // Master must reach this for half rate

    localparam int unsigned KHZ_W = 11;             // Width of a kHz command
    localparam int unsigned CNT_W = 8;              // Width of a base-clock cycle count
    localparam int unsigned NUM_W = 17;             // Width of the rounding numerator
    localparam int unsigned DEN_W = 12;             // Width of the doubled divisor

    // ************************************************************
    // Channel codes and reset values
    // ************************************************************
    localparam logic [1:0] CH_A = 2'h0;
    localparam logic [1:0] CH_B = 2'h1;
    localparam logic [1:0] CH_C = 2'h2;
    localparam logic [1:0] CH_D = 2'h3;

    localparam logic [KHZ_W-1:0] FREQ_RST_KHZ = 11'h01F4;   // 500 kHz after reset
    localparam logic [CNT_W-1:0] CNT_RST      = 8'h60;      // 96 base cycles = 500 kHz

    // Fractional tick generator: add BASE per clock, wrap at CLK
    localparam logic [8:0] TICK_INC = 9'h030;   // 48
    localparam logic [8:0] TICK_MOD = 9'h0FA;   // 250

endpackage

// ---- sfpc_div_if.sv ----
// Carrier between the control block and its divide engine.
// Assumes both ends share one clock; start is a one-cycle pulse.
`timescale 1ns/1ps
interface sfpc_div_if;
    import sfpc_pkg::*;
    logic             start;
    logic [NUM_W-1:0] num;
    logic [DEN_W-1:0] den;
    logic             busy;
    logic             done;
    logic [CNT_W-1:0] quot;

    modport ctrl   (output start, output num, output den,
                    input busy, input done, input quot);
    modport engine (input start, input num, input den,
                    output busy, output done, output quot);
endinterface

// ---- sfpc_divider.sv ----
// Sequential restoring divider producing the base-cycle count.
// Assumes num and den stay stable only at the start pulse; it latches them.
`timescale 1ns/1ps
module sfpc_divider
    import sfpc_pkg::*;
(
    input  wire logic CLK,
    input  wire logic RESETN,
    sfpc_div_if.engine dv
);

    typedef enum logic [1:0] {
        SFPC_DV_IDLE = 2'b01,
        SFPC_DV_RUN  = 2'b10
    } sfpc_dv_e;

    typedef struct packed {
        sfpc_dv_e         state;
        logic [DEN_W:0]   rem;
        logic [NUM_W-1:0] quo;
        logic [DEN_W-1:0] den;
        logic [4:0]       step;
        logic             done;
    } sfpc_dv_s;

    localparam logic [4:0] STEPS = 5'(NUM_W - 1);

    sfpc_dv_s s_q;
    sfpc_dv_s s_d;

    // One quotient bit per cycle; slow but tiny, and commands are rare
    always_comb begin
        logic [DEN_W:0] trial;
        trial  = '0;
        s_d    = s_q;
        s_d.done = 1'b0;
        unique case (s_q.state)
            SFPC_DV_IDLE: begin
                if (dv.start) begin
                    s_d.rem   = '0;
                    s_d.quo   = dv.num;
                    s_d.den   = dv.den;
                    s_d.step  = STEPS;
                    s_d.state = SFPC_DV_RUN;
                end
            end
            SFPC_DV_RUN: begin
                trial = {s_q.rem[DEN_W-1:0], s_q.quo[NUM_W-1]};
                s_d.quo = {s_q.quo[NUM_W-2:0], 1'b0};
                if (trial >= {1'b0, s_q.den}) begin
                    s_d.rem    = trial - {1'b0, s_q.den};
                    s_d.quo[0] = 1'b1;
                end else begin
                    s_d.rem = trial;
                end
                s_d.step = s_q.step - 5'h01;
                if (s_q.step == '0) begin
                    s_d.done  = 1'b1;
                    s_d.state = SFPC_DV_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            s_q       <= '0;
            s_q.state <= SFPC_DV_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign dv.busy = (s_q.state == SFPC_DV_RUN);
    assign dv.done = s_q.done;
    assign dv.quot = s_q.quo[CNT_W-1:0];   // Result always below 256 in range

endmodule

// ---- sfpc_props.sv ----
// Checker for the frequency and phase control top, watching its ports only.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
module sfpc_props
    import sfpc_pkg::*;
(
    input wire logic             CLK,
    input wire logic             RESETN,
    input wire logic             FREQ_WR,
    input wire logic             FREQ_RD,
    input wire logic [1:0]       FREQ_CH,
    input wire logic [KHZ_W-1:0] FREQ_WDATA,
    input wire logic             FREQ_ACK,
    input wire logic             FREQ_NACK,
    input wire logic             FREQ_RVALID,
    input wire logic [KHZ_W-1:0] FREQ_RDATA,
    input wire logic [3:0]       PERIOD_START,
    input wire logic [CNT_W-1:0] MASTER_CYCLES,
    input wire logic             HALF_RATE_A
);
    // ************************************************************
    // Helper: clocks since the last channel A start
    // ************************************************************
    logic [11:0] since_q;
    logic        valid_q;
    // Longest master period whose half still meets the channel A floor
    localparam int unsigned HALF_CNT_MAX = (2 * BASE_KHZ + HALF_MIN_KHZ) / (2 * HALF_MIN_KHZ);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    // Half mode drops A starts, so offsets are only timed at full rate
    always_ff @(posedge CLK) begin
        if (!RESETN || PERIOD_START[0]) since_q <= 12'h000;
        else if (since_q != 12'hFFF) since_q <= since_q + 12'h001;
        if (!RESETN || HALF_RATE_A) valid_q <= 1'b0;
        else if (PERIOD_START[0]) valid_q <= 1'b1;
    end

    // Ticks at 48/250 of the clock, so k ticks span this many clocks
    function automatic logic [11:0] clks(input logic [9:0] k);
        return 12'((k * 250) / 48);
    endfunction

    property p_offset(logic pulse, logic [9:0] k);
        (pulse && valid_q && !HALF_RATE_A) |->
            (since_q + 12'h002 >= clks(k)) && (since_q <= clks(k) + 12'h001);
    endproperty

    a_write_ack: assert property (
        (FREQ_WR && FREQ_CH != CH_C) |=> FREQ_ACK && !FREQ_NACK)
        else $error("Non-master write not acknowledged");
    a_master_accept: assert property (
        (FREQ_WR && FREQ_CH == CH_C && FREQ_WDATA >= FMIN_KHZ && FREQ_WDATA <= FMAX_KHZ)
        |=> FREQ_ACK && !FREQ_NACK)
        else $error("Master write in range not acknowledged");
    a_master_refuse: assert property (
        (FREQ_WR && FREQ_CH == CH_C && (FREQ_WDATA < FMIN_KHZ || FREQ_WDATA > FMAX_KHZ))
        |=> FREQ_NACK && !FREQ_ACK)
        else $error("Master write out of range not refused");
    a_no_spurious: assert property (
        !FREQ_WR |=> !FREQ_ACK && !FREQ_NACK)
        else $error("Answer without a write");
    a_read_valid: assert property (
        FREQ_RD |=> FREQ_RVALID)
        else $error("Read not answered");
    a_rdata_hold: assert property (
        $changed(FREQ_RDATA) |-> FREQ_RVALID)
        else $error("Read data moved without a read");
    a_phase_c: assert property (
        p_offset(PERIOD_START[2], 10'(MASTER_CYCLES >> 2)))
        else $error("Master start not a quarter period after A");
    a_phase_b: assert property (
        p_offset(PERIOD_START[1], 10'(MASTER_CYCLES >> 1)))
        else $error("Channel B start not half a period after A");
    a_phase_d: assert property (
        p_offset(PERIOD_START[3], 10'(MASTER_CYCLES >> 2) + 10'(MASTER_CYCLES >> 1)))
        else $error("Channel D start not three quarters after A");
    a_start_single: assert property (
        $onehot0(PERIOD_START))
        else $error("Two channels started together");
    a_half_floor: assert property (
        HALF_RATE_A |-> (MASTER_CYCLES <= HALF_CNT_MAX))
        else $error("Half rate on a master period that is too long");

    c_refused: cover property (FREQ_NACK);
    c_half_start: cover property (HALF_RATE_A && PERIOD_START[0]);
    c_timed_c: cover property (PERIOD_START[2] && valid_q);
endmodule

bind sfpc_top sfpc_props u_props (.CLK(CLK), .RESETN(RESETN), .FREQ_WR(FREQ_WR),
    .FREQ_RD(FREQ_RD), .FREQ_CH(FREQ_CH), .FREQ_WDATA(FREQ_WDATA), .FREQ_ACK(FREQ_ACK),
    .FREQ_NACK(FREQ_NACK), .FREQ_RVALID(FREQ_RVALID), .FREQ_RDATA(FREQ_RDATA),
    .PERIOD_START(PERIOD_START), .MASTER_CYCLES(MASTER_CYCLES), .HALF_RATE_A(HALF_RATE_A));

// ---- sfpc_host.sv ----
// Command host model issuing frequency writes and reads.
// Assumes the same clock as the block; one request per call.
`timescale 1ns/1ps
module sfpc_host
    import sfpc_pkg::*;
(
    input  wire logic             CLK,
    output logic                  FREQ_WR,
    output logic                  FREQ_RD,
    output logic [1:0]            FREQ_CH,
    output logic [KHZ_W-1:0]      FREQ_WDATA
);
    // Idle at time zero
    initial begin
        FREQ_WR    = 1'b0;
        FREQ_RD    = 1'b0;
        FREQ_CH    = 2'h0;
        FREQ_WDATA = 11'h000;
    end

    // Released lines show the inverse, so stale values never match by luck
    task automatic wr(input logic [1:0] ch, input logic [KHZ_W-1:0] d);
        @(posedge CLK);
        FREQ_WR    <= 1'b1;
        FREQ_CH    <= ch;
        FREQ_WDATA <= d;
        @(posedge CLK);
        FREQ_WR    <= 1'b0;
        FREQ_CH    <= ~ch;
        FREQ_WDATA <= ~d;
    endtask

    task automatic rd(input logic [1:0] ch);
        @(posedge CLK);
        FREQ_RD <= 1'b1;
        FREQ_CH <= ch;
        @(posedge CLK);
        FREQ_RD <= 1'b0;
        FREQ_CH <= ~ch;
    endtask
endmodule

// ---- sfpc_top_tb_top.sv ----
// Self-checking bench for the frequency and phase control top.
// Assumes the host model drives all command inputs.
`timescale 1ns/1ps
module sfpc_top_tb_top;
    import sfpc_pkg::*;
    typedef struct packed {
        logic [1:0] ch; logic [KHZ_W-1:0] d; logic nack; logic [KHZ_W-1:0] rb;
    } sfpc_row_s;
    logic clk = 1'b0, resetn = 1'b0, wr, rd, ack, nack, rvalid, half, win = 1'b0;
    logic [1:0] ch;
    logic [KHZ_W-1:0] wdata, rdata;
    logic [3:0] ps;
    logic [CNT_W-1:0] mc;
    int err_count = 0, compares = 0, na, nb, nc, nd;
    sfpc_row_s rows [8] = '{'{CH_A, 11'h12C, 1'b0, 11'h12C}, '{CH_B, 11'h4D2, 1'b0, 11'h4D2},
        '{CH_D, 11'h7FF, 1'b0, 11'h7FF}, '{CH_C, 11'h0C7, 1'b1, 11'h1F4},
        '{CH_C, 11'h7D1, 1'b1, 11'h1F4}, '{CH_C, 11'h0C8, 1'b0, 11'h0C8},
        '{CH_C, 11'h7D0, 1'b0, 11'h7D0}, '{CH_C, 11'h1F4, 1'b0, 11'h1F4}};

    always #2 clk = ~clk;
    sfpc_host u_host (.CLK(clk), .FREQ_WR(wr), .FREQ_RD(rd), .FREQ_CH(ch), .FREQ_WDATA(wdata));
    sfpc_top DUT (.CLK(clk), .RESETN(resetn), .FREQ_WR(wr), .FREQ_RD(rd), .FREQ_CH(ch),
        .FREQ_WDATA(wdata), .FREQ_ACK(ack), .FREQ_NACK(nack), .FREQ_RVALID(rvalid),
        .FREQ_RDATA(rdata), .PERIOD_START(ps), .MASTER_CYCLES(mc), .HALF_RATE_A(half));

    // Count channel starts inside a measuring window
    always @(posedge clk) begin
        if (win) begin
            na += ps[0];
            nb += ps[1];
            nc += ps[2];
            nd += ps[3];
        end
    end

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    function automatic logic near(input int a, input int b);
        return (a - b <= 2) && (b - a <= 2);
    endfunction

    // Count only changes at a period wrap, so wait with a bound
    task automatic set_master(input logic [KHZ_W-1:0] f, input logic [CNT_W-1:0] n);
        u_host.wr(CH_C, f);
        for (int i = 0; i < 3000 && mc !== n; i++) @(posedge clk);
        #1;
        check(mc, n, "master cycle count");
        if (mc !== n) report_and_stop();
    endtask

    task automatic write_a(input logic [KHZ_W-1:0] f, input logic exp_half);
        u_host.wr(CH_A, f);
        repeat (2) @(posedge clk);
        #1;
        check(half, exp_half, "half rate select");
        na = 0;
        nb = 0;
        nc = 0;
        nd = 0;
        win <= 1'b1;
        repeat (4000) @(posedge clk);
        win <= 1'b0;
        #1;
        check(near(exp_half ? 2 * na : na, nc), 1'b1, "A start rate");
        check(near(nb, nc) && near(nd, nc), 1'b1, "B and D start rate");
    endtask

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        #1;
        check(mc, 8'h60, "count after reset");
        check(half, 1'b0, "half after reset");
        // Ordinary writes, each followed by a readback of the same channel
        for (int r = 0; r < 8; r++) begin
            u_host.wr(rows[r].ch, rows[r].d);
            #1;
            check({ack, nack}, {~rows[r].nack, rows[r].nack}, "write answer");
            u_host.rd(rows[r].ch);
            #1;
            check({rvalid, rdata}, {1'b1, rows[r].rb}, "readback");
            repeat (24) @(posedge clk);
        end
        set_master(11'h1C2, 8'h6B);
        set_master(11'h300, 8'h3F);
        set_master(11'h384, 8'h35);
        u_host.wr(CH_B, 11'h0FA);
        u_host.wr(CH_D, 11'h0D2);
        repeat (1500) @(posedge clk);
        #1;
        check(mc, 8'h35, "count after B and D writes");
        write_a(11'h064, 1'b1);
        write_a(11'h7D0, 1'b0);
        write_a(11'h064, 1'b1);
        set_master(11'h15E, 8'h89);
        check(half, 1'b0, "half below 400 kHz");
        // Speed-up from a slow master: half only once the short period applies
        set_master(11'h384, 8'h35);
        check(half, 1'b1, "half once fast count applies");
        report_and_stop();
    end
endmodule
